// >>> cwt_cfg.svh
`ifndef CWT_CFG_SVH
`define CWT_CFG_SVH
// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define CWT_CLK_NS 5
`define CWT_TICK_NS 100000
`define CWT_TICK_CYC (`CWT_TICK_NS / `CWT_CLK_NS)
`define CWT_FILT_NS 16000
`define CWT_FILT_CYC ((`CWT_FILT_NS + `CWT_CLK_NS - 1) / `CWT_CLK_NS)
`define CWT_INT_PULSE_CYC 8'h10
`define CWT_RST_PULSE_CYC 8'h20
// ----------------------------------------------------------------
// On-time codes and their lengths in 0.1 ms ticks
// ----------------------------------------------------------------
`define CWT_ON_OFF 3'h0
`define CWT_ON_STAT_HI 3'h6
`define CWT_ON_STAT_LO 3'h7
`define CWT_ON_T1 24'h000001
`define CWT_ON_T2 24'h000003
`define CWT_ON_T3 24'h00000A
`define CWT_ON_T4 24'h000064
`define CWT_ON_T5 24'h0000C8
// ----------------------------------------------------------------
// Periods in 0.1 ms ticks, 10 ms up to 1000 s in 1-2-5 steps
// ----------------------------------------------------------------
`define CWT_PER_0 24'h000064
`define CWT_PER_1 24'h0000C8
`define CWT_PER_2 24'h0001F4
`define CWT_PER_3 24'h0003E8
`define CWT_PER_4 24'h0007D0
`define CWT_PER_5 24'h001388
`define CWT_PER_6 24'h002710
`define CWT_PER_7 24'h004E20
`define CWT_PER_8 24'h00C350
`define CWT_PER_9 24'h0186A0
`define CWT_PER_10 24'h030D40
`define CWT_PER_11 24'h07A120
`define CWT_PER_12 24'h0F4240
`define CWT_PER_13 24'h1E8480
`define CWT_PER_14 24'h4C4B40
`define CWT_PER_15 24'h989680
`endif

// >>> cwt_pkg.sv
`default_nettype none
`include "cwt_cfg.svh"
package cwt_pkg;
	typedef enum logic [4:0] {
		CWT_NORMAL  = 5'h01,
		CWT_STOP    = 5'h02,
		CWT_SLEEP   = 5'h04,
		CWT_RESTART = 5'h08,
		CWT_FAIL    = 5'h10
	} cwt_mode_type;

	typedef enum logic [1:0] {
		CWT_S_IDLE = 2'h1,
		CWT_S_FILT = 2'h2
	} cwt_samp_type;

	function automatic logic [23:0] period_ticks(input logic [3:0] sel);
		case (sel)
			4'h0: period_ticks = `CWT_PER_0;
			4'h1: period_ticks = `CWT_PER_1;
			4'h2: period_ticks = `CWT_PER_2;
			4'h3: period_ticks = `CWT_PER_3;
			4'h4: period_ticks = `CWT_PER_4;
			4'h5: period_ticks = `CWT_PER_5;
			4'h6: period_ticks = `CWT_PER_6;
			4'h7: period_ticks = `CWT_PER_7;
			4'h8: period_ticks = `CWT_PER_8;
			4'h9: period_ticks = `CWT_PER_9;
			4'hA: period_ticks = `CWT_PER_10;
			4'hB: period_ticks = `CWT_PER_11;
			4'hC: period_ticks = `CWT_PER_12;
			4'hD: period_ticks = `CWT_PER_13;
			4'hE: period_ticks = `CWT_PER_14;
			default: period_ticks = `CWT_PER_15;
		endcase
	endfunction

	// Zero for the off and static codes, which do not run the timer.
	function automatic logic [23:0] on_ticks(input logic [2:0] sel);
		case (sel)
			3'h1: on_ticks = `CWT_ON_T1;
			3'h2: on_ticks = `CWT_ON_T2;
			3'h3: on_ticks = `CWT_ON_T3;
			3'h4: on_ticks = `CWT_ON_T4;
			3'h5: on_ticks = `CWT_ON_T5;
			default: on_ticks = 24'h000000;
		endcase
	endfunction
endpackage
`default_nettype wire

// >>> cwt_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cwt_tick_if;
	logic       clear;
	logic       start;
	logic [3:0] period_sel;
	logic [2:0] on_sel;
	logic       running;
	logic       on_window;
	logic       period_start;
	logic       first_start;
	logic       on_end;
	modport timer (input clear, start, period_sel, on_sel,
		output running, on_window, period_start, first_start, on_end);
	modport ctrl (output clear, start, period_sel, on_sel,
		input running, on_window, period_start, first_start, on_end);
endinterface
`default_nettype wire

// >>> cwt_period_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "cwt_cfg.svh"
module cwt_period_timer #(
	parameter int unsigned TICK_CYCLES = `CWT_TICK_CYC
) (
	// Clock and reset
	input wire logic    clk,
	input wire logic    rst,
	// Timer control and events
	cwt_tick_if.timer   tk
);
	logic [31:0] pre_q, pre_d;
	logic [23:0] cnt_q, cnt_d;
	logic        run_q, run_d;
	logic        pst_q, pst_d;
	logic        first_q, first_d;
	logic        end_q, end_d;
	logic [23:0] per;
	logic [23:0] on;
	logic        tick;

	always_comb begin
		per = cwt_pkg::period_ticks(tk.period_sel);
		on = cwt_pkg::on_ticks(tk.on_sel);
		tick = (pre_q == 32'(TICK_CYCLES - 1));
		pre_d = tick ? 32'h0 : pre_q + 32'h1;
		cnt_d = cnt_q;
		run_d = run_q;
		pst_d = 1'b0;
		first_d = first_q;
		end_d = 1'b0;
		if (tk.clear) begin
			pre_d = 32'h0;
			cnt_d = 24'h0;
			run_d = 1'b0;
			first_d = 1'b0;
		end else if (tk.start) begin
			// Writing an on-time restarts the period at once. (RL12)
			pre_d = 32'h0;
			cnt_d = 24'h0;
			run_d = (on != 24'h0);
			pst_d = (on != 24'h0);
			first_d = 1'b1;
		end else if (tick && run_q) begin
			if (cnt_q >= per - 24'h1) begin
				cnt_d = 24'h0;
				pst_d = 1'b1;
				first_d = 1'b0;
			end else begin
				cnt_d = cnt_q + 24'h1;
			end
			if (cnt_q == on - 24'h1) begin
				end_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pre_q <= 32'h0;
			cnt_q <= 24'h0;
			run_q <= 1'b0;
			pst_q <= 1'b0;
			first_q <= 1'b0;
			end_q <= 1'b0;
		end else begin
			pre_q <= pre_d;
			cnt_q <= cnt_d;
			run_q <= run_d;
			pst_q <= pst_d;
			first_q <= first_d;
			end_q <= end_d;
		end
	end

	// Window opens at the start of each period and spans the on-time. (RL20)
	assign tk.on_window = run_q && (cnt_q < cwt_pkg::on_ticks(tk.on_sel));
	assign tk.running = run_q;
	assign tk.period_start = pst_q;
	assign tk.first_start = first_q;
	assign tk.on_end = end_q;
endmodule
`default_nettype wire

// >>> cwt_wake_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "cwt_cfg.svh"
// Functional notes
// (RL1) Fail-safe turns the high-side switch off and sense input to static.
// (RL2) Overcurrent or overtemperature in normal, stop or sleep turns the switch off.
// (RL3) A fault never clears the timer; only restart mode clears it.
// (RL4) Software arms cyclic sensing in normal mode before stop or sleep.
// (RL5) Sense wake sets its flag, interrupts in stop, restarts from sleep.
// (RL6) Sleep request with wake flags set restarts at once and pulses reset.
// (RL7) Software clears both wake status registers before requesting sleep.
// (RL8) Sleep overcurrent leaving only cyclic sense as wake source leaves sleep.
// (RL9) Timer wake source interrupts each period in normal and stop.
// (RL10) Timer wake source in sleep wakes through restart each period.
// (RL11) Software enables timer wake, then sets period and a valid on-time.
// (RL12) Writing on-time starts timer; every period start but the first interrupts.
// (RL13) Sixteen periods, 10 ms to 1000 s in 1-2-5 steps.
// (RL14) Five on-times plus static high and static low settings.
// (RL15) Cyclic sense and cyclic wake share one timer and setting.
// (RL16) High-side switch follows the timer when configured for it.
// (RL17) First sample is the reference; later change during on-time wakes.
// (RL18) A change counts only if stable through the filter after on-time.
// (RL19) Command fault is set when on-time exceeds the period.
// (RL20) Switch is on for exactly the on-time from each period start.
module cwt_wake_timer #(
	parameter int unsigned TICK_CYCLES = `CWT_TICK_CYC,
	parameter logic [7:0]  INT_PULSE   = `CWT_INT_PULSE_CYC,
	parameter logic [7:0]  RST_PULSE   = `CWT_RST_PULSE_CYC
) (
	// Clock and reset
	input wire logic                 clk,
	input wire logic                 rst,
	// Device mode
	input wire cwt_pkg::cwt_mode_type mode,
	input wire logic                 sleep_req,
	// Configuration
	input wire logic [3:0]           period_sel,
	input wire logic [2:0]           on_time_sel,
	input wire logic                 on_time_wr,
	input wire logic                 timer_wake_en,
	input wire logic                 sense_wake_en,
	input wire logic                 hs_timer_sel,
	input wire logic                 other_wake_en,
	// Wake status summary
	input wire logic                 wake_status_a_set,
	input wire logic                 wake_status_b_set,
	// Pins and analog fault flags
	input wire logic                 sense_wake_pin,
	input wire logic                 hs_overcurrent,
	input wire logic                 thermal_shutdown_level_two,
	// Outputs
	output logic                     high_side_switch,
	output logic                     static_sense,
	output logic                     sense_input_wake_flag,
	output logic                     timer_wake_flag,
	output logic                     sense_level,
	output logic                     interrupt_out_n,
	output logic                     reset_out_n,
	output logic                     restart_req,
	output logic                     command_fault
);
	localparam logic [11:0] FILT_CYC = 12'(`CWT_FILT_CYC);

	// ----------------------------------------------------------------
	// Synchronisers and timer
	// ----------------------------------------------------------------
	logic [2:0] s1_q, s2_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_q <= 3'h0;
			s2_q <= 3'h0;
		end else begin
			s1_q <= {thermal_shutdown_level_two, hs_overcurrent, sense_wake_pin};
			s2_q <= s1_q;
		end
	end
	logic pin_s, fault_s;
	assign pin_s = s2_q[0];
	assign fault_s = s2_q[1] | s2_q[2];

	cwt_tick_if tk();
	// One timer serves both sensing and wake with one setting. (RL15)
	assign tk.clear = (mode == cwt_pkg::CWT_RESTART); // RL3
	assign tk.start = on_time_wr;
	assign tk.period_sel = period_sel; // RL13
	assign tk.on_sel = on_time_sel; // RL14
	cwt_period_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
		.clk (clk),
		.rst (rst),
		.tk  (tk)
	);

	// ----------------------------------------------------------------
	// Control state
	// ----------------------------------------------------------------
	cwt_pkg::cwt_samp_type st_q, st_d;
	logic [11:0] fcnt_q, fcnt_d;
	logic        samp_q, samp_d, ref_q, ref_d, refv_q, refv_d;
	logic        flt_q, flt_d, hs_q, hs_d, ss_q, ss_d;
	logic        swf_q, swf_d, twf_q, twf_d, rr_q, rr_d, cf_q, cf_d;
	logic [7:0]  ic_q, ic_d, rc_q, rc_d;
	logic        int_q, int_d, rst_q, rst_d;
	logic        run_mode, fs, cyc_on, sense_ev, timer_ev, wake_ev, over, int_ev, rst_ev;

	always_comb begin
		run_mode = (mode == cwt_pkg::CWT_NORMAL) || (mode == cwt_pkg::CWT_STOP)
			|| (mode == cwt_pkg::CWT_SLEEP);
		fs = (mode == cwt_pkg::CWT_FAIL);
		over = cwt_pkg::on_ticks(on_time_sel) > cwt_pkg::period_ticks(period_sel);
		// Fault latches the switch off until the next on-time write; a new fault wins over it.
		flt_d = (fault_s & run_mode) | (flt_q & !on_time_wr); // RL2
		cyc_on = hs_timer_sel && tk.running && !flt_d && !fs;
		hs_d = 1'b0;
		if (!flt_d && !fs && hs_timer_sel) begin // RL1 RL2
			hs_d = (on_time_sel == `CWT_ON_STAT_HI) || tk.on_window; // RL16 RL20
		end
		ss_d = !cyc_on; // RL1 RL2
		st_d = st_q;
		fcnt_d = fcnt_q;
		samp_d = samp_q;
		ref_d = ref_q;
		refv_d = refv_q;
		sense_ev = 1'b0;
		case (st_q)
			cwt_pkg::CWT_S_IDLE: begin
				if (tk.on_end && cyc_on && sense_wake_en) begin
					samp_d = pin_s;
					fcnt_d = 12'h0;
					st_d = cwt_pkg::CWT_S_FILT; // RL18
				end
			end
			cwt_pkg::CWT_S_FILT: begin
				if (pin_s != samp_q || !cyc_on) begin
					st_d = cwt_pkg::CWT_S_IDLE; // RL18
				end else if (fcnt_q == FILT_CYC - 12'h1) begin
					sense_ev = refv_q && (samp_q != ref_q); // RL17
					ref_d = samp_q;
					refv_d = 1'b1;
					st_d = cwt_pkg::CWT_S_IDLE;
				end else begin
					fcnt_d = fcnt_q + 12'h1;
				end
			end
			default: st_d = cwt_pkg::CWT_S_IDLE;
		endcase
		if (on_time_wr || tk.clear) begin
			refv_d = 1'b0; // RL17
			st_d = cwt_pkg::CWT_S_IDLE;
		end
		timer_ev = tk.period_start && !tk.first_start && timer_wake_en; // RL12
		wake_ev = sense_ev || timer_ev;
		swf_d = sense_ev; // RL5
		twf_d = timer_ev;
		int_ev = wake_ev && (mode == cwt_pkg::CWT_NORMAL || mode == cwt_pkg::CWT_STOP); // RL5 RL9
		// The fault itself kills cyc_on, so the lost-source check looks at the timer directly.
		rr_d = (wake_ev && mode == cwt_pkg::CWT_SLEEP) // RL5 RL10
			|| (sleep_req && (wake_status_a_set || wake_status_b_set)) // RL6
			|| (mode == cwt_pkg::CWT_SLEEP && fault_s && !flt_q && hs_timer_sel && tk.running
				&& sense_wake_en && !other_wake_en && !timer_wake_en); // RL8
		rst_ev = rr_d; // RL6
		ic_d = int_ev ? INT_PULSE : ((ic_q != 8'h0) ? ic_q - 8'h1 : 8'h0);
		rc_d = rst_ev ? RST_PULSE : ((rc_q != 8'h0) ? rc_q - 8'h1 : 8'h0);
		int_d = (ic_d != 8'h0);
		rst_d = (rc_d != 8'h0);
		cf_d = over; // RL19
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= cwt_pkg::CWT_S_IDLE;
			fcnt_q <= 12'h0;
			samp_q <= 1'b0;
			ref_q <= 1'b0;
			refv_q <= 1'b0;
			flt_q <= 1'b0;
			hs_q <= 1'b0;
			ss_q <= 1'b1;
			swf_q <= 1'b0;
			twf_q <= 1'b0;
			rr_q <= 1'b0;
			cf_q <= 1'b0;
			ic_q <= 8'h0;
			rc_q <= 8'h0;
			int_q <= 1'b0;
			rst_q <= 1'b0;
		end else begin
			st_q <= st_d;
			fcnt_q <= fcnt_d;
			samp_q <= samp_d;
			ref_q <= ref_d;
			refv_q <= refv_d;
			flt_q <= flt_d;
			hs_q <= hs_d;
			ss_q <= ss_d;
			swf_q <= swf_d;
			twf_q <= twf_d;
			rr_q <= rr_d;
			cf_q <= cf_d;
			ic_q <= ic_d;
			rc_q <= rc_d;
			int_q <= int_d;
			rst_q <= rst_d;
		end
	end

	assign high_side_switch = hs_q;
	assign static_sense = ss_q;
	assign sense_input_wake_flag = swf_q;
	assign timer_wake_flag = twf_q;
	assign sense_level = ref_q;
	assign interrupt_out_n = !int_q;
	assign reset_out_n = !rst_q;
	assign restart_req = rr_q;
	assign command_fault = cf_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence s_restart_with_reset;
		restart_req && !reset_out_n;
	endsequence

	property p_failsafe_off;
		@(posedge clk) disable iff (rst) fs |=> !high_side_switch && static_sense;
	endproperty
	a_failsafe_off: assert property (p_failsafe_off) else $error("switch on in fail-safe"); // RL1

	property p_fault_off;
		@(posedge clk) disable iff (rst)
			(fault_s && run_mode && !on_time_wr) |=> !high_side_switch && static_sense;
	endproperty
	a_fault_off: assert property (p_fault_off) else $error("switch on after fault"); // RL2

	property p_timer_kept;
		@(posedge clk) disable iff (rst)
			(tk.running && !tk.clear && !on_time_wr) |=> tk.running;
	endproperty
	a_timer_kept: assert property (p_timer_kept) else $error("timer lost outside restart"); // RL3

	property p_sense_sleep;
		@(posedge clk) disable iff (rst)
			(sense_ev && mode == cwt_pkg::CWT_SLEEP) |=> sense_input_wake_flag
				##0 s_restart_with_reset;
	endproperty
	a_sense_sleep: assert property (p_sense_sleep) else $error("sense wake did not restart"); // RL5

	property p_sleep_flags;
		@(posedge clk) disable iff (rst)
			(sleep_req && (wake_status_a_set || wake_status_b_set)) |=> s_restart_with_reset;
	endproperty
	a_sleep_flags: assert property (p_sleep_flags) else $error("sleep with flags kept sleeping"); // RL6

	property p_cyc_int;
		@(posedge clk) disable iff (rst)
			(timer_ev && mode == cwt_pkg::CWT_NORMAL) |=> !interrupt_out_n [*8];
	endproperty
	a_cyc_int: assert property (p_cyc_int) else $error("cyclic interrupt missing"); // RL9

	property p_first_quiet;
		@(posedge clk) disable iff (rst)
			(tk.period_start && tk.first_start) |=> !timer_wake_flag;
	endproperty
	a_first_quiet: assert property (p_first_quiet) else $error("first period woke"); // RL12

	property p_cmd_fault;
		@(posedge clk) disable iff (rst) over |=> command_fault;
	endproperty
	a_cmd_fault: assert property (p_cmd_fault) else $error("command fault not set"); // RL19

	property p_hs_window;
		@(posedge clk) disable iff (rst)
			(tk.on_window && hs_timer_sel && !flt_d && !fs) |=> high_side_switch;
	endproperty
	a_hs_window: assert property (p_hs_window) else $error("switch off in window"); // RL16
endmodule
`default_nettype wire

// >>> cwt_sense_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Switch network on the sense wake pin
// ----------------------------------------------------------------
module cwt_sense_model (
	// Clock
	input wire logic clk,
	// Switched supply and contact state
	input wire logic high_side_switch,
	input wire logic contact,
	// Wake input level
	output logic     sense_wake_pin
);
	logic level_q = 1'b0;

	// Contacts are read only while the switch powers them; the pin then keeps that level.
	always @(posedge clk) begin
		if (high_side_switch)
			level_q <= contact;
	end

	assign sense_wake_pin = level_q;
endmodule
`default_nettype wire

// >>> cyclic_wake_sense_timer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "cwt_cfg.svh"
module cyclic_wake_sense_timer_tb_top;
	// ----------------------------------------------------------------
	// Stimulus and wiring
	// ----------------------------------------------------------------
	localparam int unsigned TICK = 4;
	logic clk = 1'b0;
	logic rst = 1'b1;
	cwt_pkg::cwt_mode_type mode = cwt_pkg::CWT_NORMAL;
	logic sleep_req = 1'b0, on_time_wr = 1'b0, contact = 1'b0;
	logic [3:0] period_sel = 4'h0;
	logic [2:0] on_time_sel = 3'h0;
	logic timer_wake_en = 1'b0, sense_wake_en = 1'b0, hs_timer_sel = 1'b0, other_wake_en = 1'b0;
	logic wake_status_a_set = 1'b0, wake_status_b_set = 1'b0;
	logic hs_overcurrent = 1'b0, thermal_shutdown_level_two = 1'b0;
	logic high_side_switch, static_sense, sense_input_wake_flag, timer_wake_flag, sense_level;
	logic interrupt_out_n, reset_out_n, restart_req, command_fault, sense_wake_pin;
	int fail_count = 0;
	int cmp_count = 0;
	logic [15:0] lfsr_q = 16'h005F;

	always #2.5 clk = ~clk;

	cwt_wake_timer #(.TICK_CYCLES(TICK)) dut (.clk(clk), .rst(rst), .mode(mode),
		.sleep_req(sleep_req), .period_sel(period_sel), .on_time_sel(on_time_sel),
		.on_time_wr(on_time_wr), .timer_wake_en(timer_wake_en), .sense_wake_en(sense_wake_en),
		.hs_timer_sel(hs_timer_sel), .other_wake_en(other_wake_en),
		.wake_status_a_set(wake_status_a_set), .wake_status_b_set(wake_status_b_set),
		.sense_wake_pin(sense_wake_pin), .hs_overcurrent(hs_overcurrent),
		.thermal_shutdown_level_two(thermal_shutdown_level_two),
		.high_side_switch(high_side_switch), .static_sense(static_sense),
		.sense_input_wake_flag(sense_input_wake_flag), .timer_wake_flag(timer_wake_flag),
		.sense_level(sense_level), .interrupt_out_n(interrupt_out_n), .reset_out_n(reset_out_n),
		.restart_req(restart_req), .command_fault(command_fault));

	cwt_sense_model partner (.clk(clk), .high_side_switch(high_side_switch), .contact(contact),
		.sense_wake_pin(sense_wake_pin));

	// ----------------------------------------------------------------
	// Expectations and helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] per_t(input logic [3:0] s);
		int m;
		m = (s % 3 == 0) ? 1 : ((s % 3 == 1) ? 2 : 5);
		per_t = 32'(m * 100 * (10 ** (s / 3)));
	endfunction

	function automatic logic [31:0] on_t(input logic [2:0] s);
		case (s)
			3'h1: on_t = 32'h1;
			3'h2: on_t = 32'h3;
			3'h3: on_t = 32'hA;
			3'h4: on_t = 32'h64;
			3'h5: on_t = 32'hC8;
			default: on_t = 32'h0;
		endcase
	endfunction

	function automatic void rnd();
		lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
	endfunction

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic wait_for(ref logic s, input logic v, input int lim, output int n);
		n = 0;
		while (s !== v && n < lim) begin
			@(posedge clk);
			n++;
		end
	endtask

	task automatic start(input cwt_pkg::cwt_mode_type m);
		@(posedge clk);
		rst <= 1'b1;
		mode <= m;
		timer_wake_en <= 1'b0;
		sense_wake_en <= 1'b0;
		hs_timer_sel <= 1'b0;
		wake_status_a_set <= 1'b0;
		wake_status_b_set <= 1'b0;
		hs_overcurrent <= 1'b0;
		thermal_shutdown_level_two <= 1'b0;
		cyc(5);
		rst <= 1'b0;
		cyc(2);
	endtask

	// Wake sources are enabled by the caller before this write.
	task automatic arm(input logic [3:0] p, input logic [2:0] o);
		@(posedge clk);
		period_sel <= p;
		on_time_sel <= o;
		on_time_wr <= 1'b1;
		@(posedge clk);
		on_time_wr <= 1'b0;
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		cyc(80000);
		fail_count++;
		$display("BAD watchdog expected finish seen timeout");
		results();
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		int n, hs_hi, falls, lows, flags;
		logic [2:0] o;
		logic c;
		logic prev;
		start(cwt_pkg::CWT_NORMAL);
		check("reset switch", 32'h0, {31'h0, high_side_switch});
		check("reset static", 32'h1, {31'h0, static_sense});
		check("reset irq", 32'h1, {31'h0, interrupt_out_n});
		check("reset rstout", 32'h1, {31'h0, reset_out_n});
		$display("test reset done");
		for (int k = 0; k < 2; k++) begin
			start(k == 0 ? cwt_pkg::CWT_NORMAL : cwt_pkg::CWT_STOP);
			rnd();
			o = 3'(1 + lfsr_q % 3);
			timer_wake_en <= 1'b1;
			hs_timer_sel <= 1'b1;
			arm(4'h0, o);
			hs_hi = 0;
			falls = 0;
			lows = 0;
			flags = 0;
			prev = 1'b1;
			for (int i = 0; i < 850; i++) begin
				@(posedge clk);
				hs_hi += int'(high_side_switch === 1'b1);
				falls += int'(prev === 1'b1 && interrupt_out_n === 1'b0);
				lows += int'(interrupt_out_n === 1'b0);
				flags += int'(timer_wake_flag === 1'b1);
				prev = interrupt_out_n;
			end
			check("switch on cycles", 3 * on_t(o) * TICK, 32'(hs_hi));
			check("irq count", 32'h2, 32'(falls));
			check("irq low cycles", 2 * `CWT_INT_PULSE_CYC, 32'(lows));
			check("timer flags", 32'h2, 32'(flags));
			$display("test cyclic wake %0d done", k);
		end
		for (int k = 0; k < 2; k++) begin
			start(cwt_pkg::CWT_NORMAL);
			timer_wake_en <= 1'b1;
			hs_timer_sel <= 1'b1;
			arm(4'h0, 3'h3);
			wait_for(high_side_switch, 1'b1, 20, n);
			@(posedge clk);
			if (k == 0)
				hs_overcurrent <= 1'b1;
			else
				thermal_shutdown_level_two <= 1'b1;
			cyc(6);
			check("fault switch", 32'h0, {31'h0, high_side_switch});
			check("fault static", 32'h1, {31'h0, static_sense});
			hs_overcurrent <= 1'b0;
			thermal_shutdown_level_two <= 1'b0;
			wait_for(interrupt_out_n, 1'b0, 450, n);
			check("timer kept", 32'h1, 32'(n < 450));
			wait_for(high_side_switch, 1'b1, 450, n);
			check("fault latched", 32'd450, 32'(n));
			arm(4'h0, 3'h6);
			cyc(6);
			check("static high", 32'h1, {31'h0, high_side_switch});
			arm(4'h0, 3'h7);
			cyc(6);
			check("static low", 32'h0, {31'h0, high_side_switch});
			arm(4'h0, 3'h6);
			mode <= cwt_pkg::CWT_FAIL;
			cyc(6);
			check("failsafe switch", 32'h0, {31'h0, high_side_switch});
			check("failsafe static", 32'h1, {31'h0, static_sense});
			$display("test fault %0d done", k);
		end
		start(cwt_pkg::CWT_NORMAL);
		for (int i = 0; i < 9; i++) begin
			rnd();
			if (i < 3)
				arm(4'(i == 2), 3'(5 - (i == 1)));
			else
				arm({3'h0, lfsr_q[0]}, lfsr_q[6:4]);
			cyc(3);
			check("cmd fault", 32'(on_t(on_time_sel) > per_t(period_sel)), {31'h0, command_fault});
		end
		$display("test command fault done");
		for (int k = 0; k < 3; k++) begin
			start(cwt_pkg::CWT_SLEEP);
			wake_status_a_set <= (k == 0);
			wake_status_b_set <= (k == 1);
			@(posedge clk);
			sleep_req <= 1'b1;
			@(posedge clk);
			sleep_req <= 1'b0;
			@(posedge clk);
			check("sleep restart", 32'(k < 2), {31'h0, restart_req});
			wait_for(reset_out_n, 1'b1, 100, n);
			check("rstout width", k < 2 ? `CWT_RST_PULSE_CYC : 0, 32'(n));
		end
		$display("test sleep check done");
		start(cwt_pkg::CWT_NORMAL);
		timer_wake_en <= 1'b1;
		arm(4'h0, 3'h1);
		mode <= cwt_pkg::CWT_SLEEP;
		wait_for(restart_req, 1'b1, 850, n);
		check("sleep timer wake", 32'h1, 32'(n < 850));
		mode <= cwt_pkg::CWT_RESTART;
		cyc(2);
		mode <= cwt_pkg::CWT_NORMAL;
		wait_for(interrupt_out_n, 1'b0, 850, n);
		check("restart clears timer", 32'd850, 32'(n));
		for (int k = 0; k < 2; k++) begin
			start(cwt_pkg::CWT_NORMAL);
			sense_wake_en <= 1'b1;
			hs_timer_sel <= 1'b1;
			other_wake_en <= (k == 1);
			arm(4'h0, 3'h1);
			mode <= cwt_pkg::CWT_SLEEP;
			hs_overcurrent <= 1'b1;
			wait_for(restart_req, 1'b1, 20, n);
			check("only source lost", 32'(k == 0), 32'(n < 20));
		end
		other_wake_en <= 1'b0;
		$display("test sleep wake done");
		for (int k = 0; k < 2; k++) begin
			rnd();
			c = lfsr_q[0];
			contact <= c;
			start(cwt_pkg::CWT_NORMAL);
			sense_wake_en <= 1'b1;
			hs_timer_sel <= 1'b1;
			arm(4'h3, 3'h1);
			mode <= k == 0 ? cwt_pkg::CWT_STOP : cwt_pkg::CWT_SLEEP;
			wait_for(sense_input_wake_flag, 1'b1, 3600, n);
			check("reference no wake", 32'd3600, 32'(n));
			contact <= ~c;
			wait_for(sense_input_wake_flag, 1'b1, 9000, n);
			check("sense wake", 32'h1, 32'(n < 9000));
			if (k == 0)
				wait_for(interrupt_out_n, 1'b0, 4, n);
			else
				wait_for(restart_req, 1'b1, 4, n);
			check("sense reaction", 32'h1, 32'(n < 4));
			check("sense level", {31'h0, ~c}, {31'h0, sense_level});
			$display("test sense %0d done", k);
		end
		results();
	end
endmodule
`default_nettype wire
